// file: hdl/uvp_map.svh
`ifndef UVP_MAP_SVH
`define UVP_MAP_SVH

// timing
`define UVP_CLK_HZ 25000000
`define UVP_TICK_MS 1
`define UVP_MS_CYCLES (`UVP_CLK_HZ / 1000 * `UVP_TICK_MS)
`define UVP_SLOW_TICK_MS 10
`define UVP_BLOCK_HOLD_MS 16'h0014
`define UVP_RELAY_PULSE_MS 16'h0064

// scaling of percentage settings
`define UVP_PCT_SCALE 7'h64
`define UVP_PCT2_SCALE 14'h2710
`define UVP_MIN_VOLT_PCT 7'h28

// register byte offsets
`define UVP_OFS_CTRL 8'h00
`define UVP_OFS_PICKUP 8'h04
`define UVP_OFS_RATIO 8'h08
`define UVP_OFS_PKDLY 8'h0c
`define UVP_OFS_TRIPDLY 8'h10
`define UVP_OFS_DODLY 8'h14
`define UVP_OFS_NOMINAL 8'h18
`define UVP_OFS_STATUS 8'h1c
`define UVP_OFS_IRQ_STAT 8'h20
`define UVP_OFS_IRQ_MASK 8'h24
`define UVP_OFS_CNT_PICKUP 8'h28
`define UVP_OFS_CNT_TRIP 8'h2c
`define UVP_OFS_CNT_PAIR0 8'h30
`define UVP_OFS_CNT_PAIR1 8'h34
`define UVP_OFS_CNT_PAIR2 8'h38

// control register fields
`define UVP_CTRL_ENABLE 0
`define UVP_CTRL_GROUP_LO 4
`define UVP_CTRL_GROUP_HI 5
`define UVP_CTRL_OPMODE_LO 8
`define UVP_CTRL_OPMODE_HI 11
`define UVP_CTRL_BLKSRC_LO 12
`define UVP_CTRL_BLKSRC_HI 14
`define UVP_CTRL_FUSE 16
`define UVP_CTRL_VARIANT_LO 18
`define UVP_CTRL_VARIANT_HI 19
`define UVP_CTRL_RELAY 20
`define UVP_CTRL_RST 32'h00000000

// setting limits and reset values (hundredths, ms, or 10 ms units; nominal in measurement counts)
`define UVP_PICKUP_MIN 16'h000a
`define UVP_PICKUP_RST 16'h005f
`define UVP_PICKUP_MAX 16'h00c8
`define UVP_RATIO_MIN 16'h0065
`define UVP_RATIO_RST 16'h0069
`define UVP_RATIO_MAX 16'h012c
`define UVP_PKDLY_RST 16'h0005
`define UVP_PKDLY_MAX 16'h03e8
`define UVP_TRIPDLY_RST 16'h00c8
`define UVP_TRIPDLY_MAX 16'h7530
`define UVP_DODLY_RST 16'h0014
`define UVP_DODLY_MAX 16'h1770
`define UVP_NOMINAL_RST 16'h1000

`endif

// file: hdl/uvp_pkg.sv
package uvp_pkg;
	typedef enum logic [1:0] {
		UVP_VAR_PHASE = 2'h0,
		UVP_VAR_POSSEQ = 2'h1,
		UVP_VAR_REMANENT = 2'h2
	} uvp_variant_e;

	typedef enum logic [2:0] {
		RLY_IDLE = 3'h1,
		RLY_PULSE = 3'h2,
		RLY_HOLD = 3'h4
	} uvp_relay_e;
endpackage

// file: hdl/uvp_stage.sv
module uvp_stage (
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// timebase
	input wire logic msTick,
	input wire logic slowTick,
	// conditions
	input wire logic run,
	input wire logic fault,
	input wire logic recovered,
	// settings
	input wire logic [15:0] pickupDelay,
	input wire logic [15:0] dropDelay,
	// result
	output logic pickup
);
	logic [15:0] pdCnt;
	logic [15:0] ddCnt;
	logic armed;

	// short dips restart the filter, so only a lasting fault arms pickup
	always_ff @(posedge clock)
	begin
		if (!nrst || !run || !fault || pickup)
			pdCnt <= 16'h0000;
		else if (msTick && pdCnt < pickupDelay)
			pdCnt <= pdCnt + 16'h0001; // [R04]
	end

	assign armed = fault && (pdCnt >= pickupDelay); // [R04]

	// a relapse below the reset level restarts the drop-out wait
	always_ff @(posedge clock)
	begin
		if (!nrst || !run || !pickup || !recovered)
			ddCnt <= 16'h0000;
		else if (slowTick && ddCnt < dropDelay)
			ddCnt <= ddCnt + 16'h0001; // [R05]
	end

	always_ff @(posedge clock)
	begin
		if (!nrst || !run)
			pickup <= 1'b0; // [R01] [R07]
		else if (!pickup && armed)
			pickup <= 1'b1; // [R18]
		else if (pickup && recovered && ddCnt >= dropDelay)
			pickup <= 1'b0; // [R05] [R06]
	end
endmodule

// file: hdl/uvp_element.sv
// Contract
// [R01] Element works only when enabled and the active group's operate mode is on.
// [R02] Pickup threshold 0.10 to 2.00 of nominal voltage, default 0.95.
// [R03] Trip delay 0.00 to 300.00 s, default 2.00 s.
// [R04] Fault must persist for pickup delay, up to 1000 ms, default 5 ms.
// [R05] Pickup held for drop-out delay 0 to 60 s, default 0.20 s.
// [R06] Reset level is pickup value times drop-out ratio 1.01 to 3.00.
// [R07] Pickup blocked by none or one of four selected user variables.
// [R08] Pickup counter counts every pickup event.
// [R09] Phase variant counts pickups separately for each of three line pairs.
// [R10] Trip counter counts every trip issued.
// [R11] Positive sequence variant uses one input, picks up below threshold.
// [R12] Positive sequence variant blocked by user signal or fuse failure.
// [R13] Positive sequence variant blocked below 40 percent of nominal voltage.
// [R14] Block is held briefly after every blocking cause has cleared.
// [R15] Trip mapped to a relay is issued as a pulse.
// [R16] Remanent variant picks up when pair one-two voltage falls below threshold.
// [R17] Several positive sequence instances with own settings run independently.
// [R18] Phase variant picks up when any line-pair voltage falls below threshold.
// [R19] Trip only after pickup held for trip delay; trip clears with pickup.
`include "uvp_map.svh"

module uvp_element #(
	parameter int MS_CYCLES = `UVP_MS_CYCLES,
	parameter int VW = 16,
	parameter int CNT_W = 16,
	parameter logic [15:0] NOMINAL_RESET = `UVP_NOMINAL_RST
) (
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// apb slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// measurements, same clock domain
	input wire logic [VW-1:0] linePairOneTwo,
	input wire logic [VW-1:0] linePairTwoThree,
	input wire logic [VW-1:0] linePairThreeOne,
	input wire logic [VW-1:0] positiveSequenceVoltage,
	// blocking sources
	input wire logic [3:0] userVariable,
	input wire logic fuseFailure,
	// protection outputs
	output logic pickup,
	output logic trip,
	output logic tripRelay,
	output logic [2:0] pairPickup,
	output logic blocked,
	output logic irq
);
	localparam int MSW = $clog2(MS_CYCLES);

	logic [31:0] ctrl;
	logic [15:0] pickupSet;
	logic [15:0] ratioSet;
	logic [15:0] pickupDelay;
	logic [15:0] tripDelay;
	logic [15:0] dropDelay;
	logic [15:0] nominal;
	logic [2:0] irqStat;
	logic [2:0] irqMask;
	logic [2:0] next_irqStat;
	logic [CNT_W-1:0] cntPickup;
	logic [CNT_W-1:0] cntTrip;
	logic [CNT_W-1:0] cntPair [3];
	logic [31:0] readValue;
	logic readErr;
	logic wrEn;
	logic [MSW-1:0] msDiv;
	logic [3:0] slowDiv;
	logic msTick;
	logic slowTick;
	logic [23:0] thrProd;
	logic [32:0] resetProd;
	logic [22:0] minProd;
	logic [VW-1:0] pairVolt [3];
	logic [2:0] stagePick;
	logic [2:0] pairPrev;
	logic active;
	logic lowVolt;
	logic userBlock;
	logic rawBlock;
	logic run;
	logic [15:0] holdCnt;
	logic [15:0] tripCnt;
	logic next_pickup;
	logic next_trip;
	logic [15:0] pulseCnt;
	uvp_pkg::uvp_relay_e relayState;
	uvp_pkg::uvp_variant_e variant;

	function automatic logic [15:0] clampSet(input logic [15:0] v, input logic [15:0] lo,
		input logic [15:0] hi);
		clampSet = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	// ---------------- apb ----------------
	// one wait state: prdata and pready both come from flops
	assign wrEn = psel && penable && pready && pwrite;

	always_comb
	begin
		readErr = 1'b0;
		readValue = 32'h00000000;
		case (paddr)
			`UVP_OFS_CTRL: readValue = ctrl;
			`UVP_OFS_PICKUP: readValue = {16'h0000, pickupSet};
			`UVP_OFS_RATIO: readValue = {16'h0000, ratioSet};
			`UVP_OFS_PKDLY: readValue = {16'h0000, pickupDelay};
			`UVP_OFS_TRIPDLY: readValue = {16'h0000, tripDelay};
			`UVP_OFS_DODLY: readValue = {16'h0000, dropDelay};
			`UVP_OFS_NOMINAL: readValue = {16'h0000, nominal};
			`UVP_OFS_STATUS: readValue = {26'h0000000, stagePick, blocked, trip, pickup};
			`UVP_OFS_IRQ_STAT: readValue = {29'h00000000, irqStat};
			`UVP_OFS_IRQ_MASK: readValue = {29'h00000000, irqMask};
			`UVP_OFS_CNT_PICKUP: readValue = 32'(cntPickup);
			`UVP_OFS_CNT_TRIP: readValue = 32'(cntTrip);
			`UVP_OFS_CNT_PAIR0: readValue = 32'(cntPair[0]);
			`UVP_OFS_CNT_PAIR1: readValue = 32'(cntPair[1]);
			`UVP_OFS_CNT_PAIR2: readValue = 32'(cntPair[2]);
			default: readErr = 1'b1;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel && penable && !pready;
			prdata <= (psel && penable && !pready && !pwrite) ? readValue : 32'h00000000;
			pslverr <= psel && penable && !pready && readErr;
		end
	end

	// out-of-range writes are clamped so the element never runs on an illegal setting
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			ctrl <= `UVP_CTRL_RST;
			pickupSet <= `UVP_PICKUP_RST;
			ratioSet <= `UVP_RATIO_RST;
			pickupDelay <= `UVP_PKDLY_RST;
			tripDelay <= `UVP_TRIPDLY_RST;
			dropDelay <= `UVP_DODLY_RST;
			nominal <= NOMINAL_RESET;
			irqMask <= 3'h0;
		end
		else if (wrEn)
		begin
			case (paddr)
				`UVP_OFS_CTRL: ctrl <= pwdata; // [R17]
				`UVP_OFS_PICKUP:
					pickupSet <= clampSet(pwdata[15:0], `UVP_PICKUP_MIN, `UVP_PICKUP_MAX); // [R02]
				`UVP_OFS_RATIO:
					ratioSet <= clampSet(pwdata[15:0], `UVP_RATIO_MIN, `UVP_RATIO_MAX); // [R06]
				`UVP_OFS_PKDLY:
					pickupDelay <= clampSet(pwdata[15:0], 16'h0000, `UVP_PKDLY_MAX); // [R04]
				`UVP_OFS_TRIPDLY:
					tripDelay <= clampSet(pwdata[15:0], 16'h0000, `UVP_TRIPDLY_MAX); // [R03]
				`UVP_OFS_DODLY:
					dropDelay <= clampSet(pwdata[15:0], 16'h0000, `UVP_DODLY_MAX); // [R05]
				`UVP_OFS_NOMINAL: nominal <= pwdata[15:0];
				`UVP_OFS_IRQ_MASK: irqMask <= pwdata[2:0];
				default: ;
			endcase
		end
	end

	assign variant = uvp_pkg::uvp_variant_e'(ctrl[`UVP_CTRL_VARIANT_HI:`UVP_CTRL_VARIANT_LO]);

	// ---------------- timebase ----------------
	assign msTick = (msDiv == MSW'(MS_CYCLES - 1));
	assign slowTick = msTick && (slowDiv == 4'(`UVP_SLOW_TICK_MS - 1));

	always_ff @(posedge clock)
	begin
		if (!nrst || msTick)
			msDiv <= '0;
		else
			msDiv <= msDiv + MSW'(1);
	end

	always_ff @(posedge clock)
	begin
		if (!nrst || slowTick)
			slowDiv <= 4'h0;
		else if (msTick)
			slowDiv <= slowDiv + 4'h1;
	end

	// ---------------- thresholds ----------------
	// products are registered; a setting change is seen one cycle later, two for resetProd after a pickupSet or nominal change
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			thrProd <= 24'h000000;
			resetProd <= 33'h000000000;
			minProd <= 23'h000000;
		end
		else
		begin
			thrProd <= nominal * pickupSet[7:0]; // [R02]
			resetProd <= thrProd * ratioSet[8:0]; // [R06]
			minProd <= nominal * `UVP_MIN_VOLT_PCT; // [R13]
		end
	end

	// ---------------- blocking ----------------
	assign active = ctrl[`UVP_CTRL_ENABLE] &&
		ctrl[`UVP_CTRL_OPMODE_LO + ctrl[`UVP_CTRL_GROUP_HI:`UVP_CTRL_GROUP_LO]] && // [R01]
		(variant == uvp_pkg::UVP_VAR_PHASE || variant == uvp_pkg::UVP_VAR_POSSEQ ||
		variant == uvp_pkg::UVP_VAR_REMANENT);

	assign lowVolt = (positiveSequenceVoltage * `UVP_PCT_SCALE) < minProd; // [R13]

	always_comb
	begin
		userBlock = 1'b0;
		case (ctrl[`UVP_CTRL_BLKSRC_HI:`UVP_CTRL_BLKSRC_LO])
			3'h1: userBlock = userVariable[0]; // [R07]
			3'h2: userBlock = userVariable[1];
			3'h3: userBlock = userVariable[2];
			3'h4: userBlock = userVariable[3];
			default: userBlock = 1'b0;
		endcase
	end

	assign rawBlock = userBlock ||
		(ctrl[`UVP_CTRL_FUSE] && fuseFailure && variant != uvp_pkg::UVP_VAR_REMANENT) || // [R12]
		(variant == uvp_pkg::UVP_VAR_POSSEQ && lowVolt); // [R13]

	// the hold stops a collapsing block from letting a stale fault trip
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			blocked <= 1'b0;
			holdCnt <= 16'h0000;
		end
		else if (rawBlock)
		begin
			blocked <= 1'b1;
			holdCnt <= 16'h0000;
		end
		else if (blocked && msTick)
		begin
			holdCnt <= holdCnt + 16'h0001;
			if (holdCnt + 16'h0001 >= `UVP_BLOCK_HOLD_MS)
				blocked <= 1'b0; // [R14]
		end
	end

	assign run = active && !blocked; // [R01] [R07]

	// ---------------- measuring stages ----------------
	assign pairVolt[0] = (variant == uvp_pkg::UVP_VAR_POSSEQ) ? positiveSequenceVoltage :
		linePairOneTwo; // [R11] [R16]
	assign pairVolt[1] = linePairTwoThree;
	assign pairVolt[2] = linePairThreeOne;

	for (genvar i = 0; i < 3; i++)
	begin : gPair
		logic [22:0] v100;
		logic [29:0] v10000;
		logic stageRun;

		assign v100 = pairVolt[i] * `UVP_PCT_SCALE;
		assign v10000 = pairVolt[i] * `UVP_PCT2_SCALE;
		// pairs two and three only take part in the phase variant
		assign stageRun = run && (i == 0 || variant == uvp_pkg::UVP_VAR_PHASE); // [R18]

		uvp_stage uStage (
			.clock(clock),
			.nrst(nrst),
			.msTick(msTick),
			.slowTick(slowTick),
			.run(stageRun),
			.fault(v100 < thrProd), // [R11] [R16] [R18]
			.recovered(v10000 >= resetProd), // [R06]
			.pickupDelay(pickupDelay),
			.dropDelay(dropDelay),
			.pickup(stagePick[i])
		);

		always_ff @(posedge clock)
		begin
			if (!nrst)
				cntPair[i] <= '0;
			else if (wrEn && paddr == `UVP_OFS_CNT_PAIR0 + 8'(4 * i))
				cntPair[i] <= '0;
			else if (variant == uvp_pkg::UVP_VAR_PHASE && stagePick[i] && !pairPrev[i])
				cntPair[i] <= cntPair[i] + CNT_W'(1); // [R09]
		end
	end

	assign pairPickup = stagePick;

	// ---------------- pickup and trip ----------------
	assign next_pickup = |stagePick; // [R18]
	assign next_trip = pickup && next_pickup && (tripCnt >= tripDelay); // [R19]

	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			pickup <= 1'b0;
			pairPrev <= 3'h0;
			trip <= 1'b0;
		end
		else
		begin
			pickup <= next_pickup;
			pairPrev <= stagePick;
			trip <= next_trip; // [R03] [R19]
		end
	end

	always_ff @(posedge clock)
	begin
		if (!nrst || !pickup)
			tripCnt <= 16'h0000; // [R19]
		else if (slowTick && tripCnt < tripDelay)
			tripCnt <= tripCnt + 16'h0001; // [R03]
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
			cntPickup <= '0;
		else if (wrEn && paddr == `UVP_OFS_CNT_PICKUP)
			cntPickup <= '0;
		else if (next_pickup && !pickup)
			cntPickup <= cntPickup + CNT_W'(1); // [R08]
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
			cntTrip <= '0;
		else if (wrEn && paddr == `UVP_OFS_CNT_TRIP)
			cntTrip <= '0;
		else if (next_trip && !trip)
			cntTrip <= cntTrip + CNT_W'(1); // [R10]
	end

	// a level trip would hold the breaker-failure timer running; the pulse re-arms only
	// after the trip has fallen
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			relayState <= uvp_pkg::RLY_IDLE;
			tripRelay <= 1'b0;
			pulseCnt <= 16'h0000;
		end
		else
		begin
			case (relayState)
				uvp_pkg::RLY_IDLE:
				begin
					pulseCnt <= 16'h0000;
					if (ctrl[`UVP_CTRL_RELAY] && next_trip && !trip)
					begin
						relayState <= uvp_pkg::RLY_PULSE;
						tripRelay <= 1'b1; // [R15]
					end
					else
						tripRelay <= !ctrl[`UVP_CTRL_RELAY] && next_trip;
				end
				uvp_pkg::RLY_PULSE:
				begin
					if (msTick)
						pulseCnt <= pulseCnt + 16'h0001;
					if (msTick && pulseCnt + 16'h0001 >= `UVP_RELAY_PULSE_MS)
					begin
						relayState <= uvp_pkg::RLY_HOLD;
						tripRelay <= 1'b0; // [R15]
					end
				end
				uvp_pkg::RLY_HOLD:
				begin
					tripRelay <= 1'b0;
					if (!next_trip)
						relayState <= uvp_pkg::RLY_IDLE;
				end
				default:
				begin
					relayState <= uvp_pkg::RLY_IDLE;
					tripRelay <= 1'b0;
				end
			endcase
		end
	end

	// ---------------- interrupts ----------------
	// a new event in the clearing cycle survives the clear
	always_comb
	begin
		next_irqStat = irqStat;
		if (wrEn && paddr == `UVP_OFS_IRQ_STAT)
			next_irqStat = irqStat & ~pwdata[2:0];
		next_irqStat = next_irqStat | {pickup && !next_pickup, next_trip && !trip,
			next_pickup && !pickup};
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			irqStat <= 3'h0;
			irq <= 1'b0;
		end
		else
		begin
			irqStat <= next_irqStat;
			irq <= |(next_irqStat & irqMask);
		end
	end
endmodule

// file: tb/uvp_element_assertions.sv
module uvp_element_chk (
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// register bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	// protection outputs
	input wire logic pickup,
	input wire logic trip,
	input wire logic tripRelay,
	input wire logic [2:0] pairPickup,
	input wire logic blocked
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);
	// an access edge that has not been answered yet
	sequence s_access;
		psel && penable && !pready;
	endsequence
	property p_answer;
		s_access |=> pready;
	endproperty
	a_answer: assert property (p_answer) else $error("access not answered next cycle");
	property p_readyPulse;
		pready |=> !pready;
	endproperty
	a_readyPulse: assert property (p_readyPulse) else $error("ready longer than one cycle");
	property p_errWithReady;
		pslverr |-> pready;
	endproperty
	a_errWithReady: assert property (p_errWithReady) else $error("error without ready");
	property p_tripNeedsPickup;
		trip |-> pickup;
	endproperty
	a_tripNeedsPickup: assert property (p_tripNeedsPickup) else $error("trip without pickup");
	property p_riseNoTrip;
		$rose(pickup) |-> !trip;
	endproperty
	a_riseNoTrip: assert property (p_riseNoTrip) else $error("trip with pickup rise");
	property p_stageLeads;
		$rose(pickup) |-> $past(pairPickup) != 3'h0;
	endproperty
	a_stageLeads: assert property (p_stageLeads) else $error("pickup with no stage");
	property p_blockedQuiet;
		blocked [*2] |-> pairPickup == 3'h0;
	endproperty
	a_blockedQuiet: assert property (p_blockedQuiet) else $error("stage up while blocked");
	property p_relayRise;
		$rose(tripRelay) |-> trip;
	endproperty
	a_relayRise: assert property (p_relayRise) else $error("relay drive without trip");
endmodule
bind uvp_element uvp_element_chk u_chk (
	.clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pready(pready),
	.pslverr(pslverr), .pickup(pickup), .trip(trip), .tripRelay(tripRelay),
	.pairPickup(pairPickup), .blocked(blocked)
);

// file: tb/uvp_front_end.sv
module uvp_front_end (
	// clock
	input wire logic clock,
	// wanted magnitudes
	input wire logic [15:0] level12,
	input wire logic [15:0] level23,
	input wire logic [15:0] level31,
	input wire logic [15:0] levelPos,
	// measured magnitudes
	output logic [15:0] volt12,
	output logic [15:0] volt23,
	output logic [15:0] volt31,
	output logic [15:0] voltPos
);
	timeunit 1ns;
	timeprecision 1ns;
	// one count of ripple, so no frozen value ever meets a threshold by luck
	logic ripple = 1'b0;
	always_ff @(posedge clock)
	begin
		ripple <= ~ripple;
		volt12 <= level12 + {15'h0, ripple};
		volt23 <= level23 + {15'h0, ripple};
		volt31 <= level31 + {15'h0, ripple};
		voltPos <= levelPos + {15'h0, ripple};
	end
endmodule

// file: tb/uvp_element_tb_top.sv
module uvp_element_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [15:0] HI = 16'h1000;
	localparam logic [15:0] LO = 16'h0bb8;
	localparam logic [15:0] DEEP = 16'h03e8;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0, prdata, rdata;
	logic pready, pslverr, rerr;
	logic [15:0] lv12 = HI, lv23 = HI, lv31 = HI, lvPos = HI, v12, v23, v31, vPos;
	logic [3:0] userVariable = 4'h0;
	logic fuseFailure = 1'b0;
	logic pickup, trip, tripRelay, blocked, irq;
	logic [2:0] pairPickup;
	// second instance with settings of its own, on the same measurements
	logic sel2 = 1'b0;
	logic [31:0] prdata2;
	logic pready2, pslverr2, pickup2;
	int miscompares = 0;
	int checked = 0;
	int cycles = 0;
	logic [7:0] ofs [6] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
	logic [31:0] rst [6] = '{32'h5f, 32'h69, 32'h5, 32'hc8, 32'h14, 32'h1000};

	always #20 clock = ~clock;

	uvp_front_end fe (
		.clock(clock), .level12(lv12), .level23(lv23), .level31(lv31), .levelPos(lvPos),
		.volt12(v12), .volt23(v23), .volt31(v31), .voltPos(vPos)
	);
	// short millisecond so every delay scales down
	uvp_element #(.MS_CYCLES(10)) dut (
		.clock(clock), .nrst(nrst), .paddr(paddr), .psel(psel && !sel2), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .linePairOneTwo(v12), .linePairTwoThree(v23),
		.linePairThreeOne(v31), .positiveSequenceVoltage(vPos),
		.userVariable(userVariable), .fuseFailure(fuseFailure), .pickup(pickup),
		.trip(trip), .tripRelay(tripRelay), .pairPickup(pairPickup), .blocked(blocked),
		.irq(irq)
	);
	uvp_element #(.MS_CYCLES(10)) dut2 (
		.clock(clock), .nrst(nrst), .paddr(paddr), .psel(psel && sel2), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata2), .pready(pready2),
		.pslverr(pslverr2), .linePairOneTwo(v12), .linePairTwoThree(v23),
		.linePairThreeOne(v31), .positiveSequenceVoltage(vPos),
		.userVariable(userVariable), .fuseFailure(fuseFailure), .pickup(pickup2),
		.trip(), .tripRelay(), .pairPickup(), .blocked(), .irq()
	);

	task automatic end_of_test();
		if (miscompares == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic flag(input logic got, input logic exp);
		cmp({31'h0, got}, {31'h0, exp});
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clock);
	endtask

	// request held until the edge that samples pready high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while ((sel2 ? pready2 : pready) !== 1'b1)
			@(posedge clock);
		rdata = sel2 ? prdata2 : prdata;
		rerr = sel2 ? pslverr2 : pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic chk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		cmp(rdata, exp);
	endtask

	task automatic setV(input logic [15:0] a, b, c, p);
		@(posedge clock);
		lv12 <= a;
		lv23 <= b;
		lv31 <= c;
		lvPos <= p;
	endtask

	// s: 0 pickup, 1 trip, 2 blocked
	task automatic waitFor(input int s, input logic lvl, input int n);
		logic v;
		for (int i = 0; i < n; i++)
		begin
			v = (s == 0) ? pickup : (s == 1) ? trip : blocked;
			if (v === lvl)
				break;
			@(posedge clock);
		end
		v = (s == 0) ? pickup : (s == 1) ? trip : blocked;
		flag(v, lvl);
	endtask

	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		if (cycles == 30000)
		begin
			miscompares++;
			$display("[ERR] %0t: timeout", $time);
			end_of_test();
		end
	end

	initial
	begin
		repeat (16) @(posedge clock);
		nrst <= 1'b1;
		for (int i = 0; i < 6; i++)
			chk(ofs[i], rst[i]);
		chk(8'h00, 32'h0);
		wr(8'h04, 32'h5);
		chk(8'h04, 32'ha);
		wr(8'h04, 32'h12c);
		chk(8'h04, 32'hc8);
		wr(8'h08, 32'h64);
		chk(8'h08, 32'h65);
		wr(8'h08, 32'h1f4);
		chk(8'h08, 32'h12c);
		apb(1'b0, 8'h40, 32'h0);
		flag(rerr, 1'b1);
		cmp(rdata, 32'h0);
		wr(8'h04, 32'h5f);
		wr(8'h08, 32'h69);
		wr(8'h0c, 32'h2);
		wr(8'h10, 32'h2);
		wr(8'h14, 32'h3);
		// the second instance runs positive sequence with a very low threshold
		sel2 <= 1'b1;
		wr(8'h04, 32'h0);
		wr(8'h00, 32'h40211);
		chk(8'h04, 32'ha);
		sel2 <= 1'b0;
		chk(8'h04, 32'h5f);
		// group one active but only group zero operates; unselected variables set
		wr(8'h00, 32'h111);
		userVariable <= 4'hf;
		setV(LO, HI, HI, HI);
		idle(200);
		flag(pickup, 1'b0);
		wr(8'h00, 32'h211);
		for (int i = 0; i < 3; i++)
		begin
			setV(i == 0 ? LO : HI, i == 1 ? LO : HI, i == 2 ? LO : HI, HI);
			waitFor(0, 1'b1, 100);
			cmp({29'h0, pairPickup}, 32'h1 << i);
			idle(80);
			flag(trip, 1'b0);
			waitFor(1, 1'b1, 200);
			flag(tripRelay, 1'b1);
			setV(HI, HI, HI, HI);
			idle(150);
			flag(pickup, 1'b1);
			waitFor(0, 1'b0, 200);
			flag(trip, 1'b0);
		end
		chk(8'h28, 32'h3);
		chk(8'h2c, 32'h3);
		for (int i = 0; i < 3; i++)
			chk(8'h30 + 8'(4 * i), 32'h1);
		setV(LO, HI, HI, HI);
		idle(4);
		setV(HI, HI, HI, HI);
		idle(100);
		flag(pickup, 1'b0);
		chk(8'h28, 32'h3);
		flag(irq, 1'b0);
		chk(8'h20, 32'h7);
		wr(8'h24, 32'h1);
		idle(2);
		flag(irq, 1'b1);
		wr(8'h20, 32'h7);
		idle(2);
		flag(irq, 1'b0);
		chk(8'h20, 32'h0);
		for (int k = 1; k < 5; k++)
		begin
			wr(8'h00, 32'h211 | (k << 12));
			userVariable <= 4'h1 << (k - 1);
			setV(LO, HI, HI, HI);
			idle(100);
			flag(blocked, 1'b1);
			flag(pickup, 1'b0);
			userVariable <= 4'h0;
			idle(150);
			flag(blocked, 1'b1);
			waitFor(2, 1'b0, 150);
			waitFor(0, 1'b1, 100);
			setV(HI, HI, HI, HI);
			waitFor(0, 1'b0, 400);
		end
		wr(8'h00, 32'h40211);
		setV(HI, HI, HI, DEEP);
		idle(100);
		flag(blocked, 1'b1);
		flag(pickup, 1'b0);
		setV(LO, LO, LO, LO);
		waitFor(2, 1'b0, 300);
		waitFor(0, 1'b1, 100);
		flag(pickup2, 1'b0);
		wr(8'h00, 32'h50211);
		fuseFailure <= 1'b1;
		idle(5);
		flag(blocked, 1'b1);
		flag(pickup, 1'b0);
		fuseFailure <= 1'b0;
		setV(HI, HI, HI, HI);
		waitFor(2, 1'b0, 300);
		wr(8'h00, 32'h80211);
		setV(HI, LO, LO, LO);
		idle(100);
		flag(pickup, 1'b0);
		setV(LO, HI, HI, HI);
		waitFor(0, 1'b1, 100);
		wr(8'h00, 32'h180211);
		waitFor(1, 1'b1, 300);
		idle(2);
		flag(tripRelay, 1'b1);
		idle(900);
		flag(tripRelay, 1'b1);
		idle(200);
		flag(tripRelay, 1'b0);
		flag(trip, 1'b1);
		// the idle variant code stops the element
		wr(8'h00, 32'hc0211);
		idle(5);
		flag(pickup, 1'b0);
		end_of_test();
	end
endmodule
